// ---- shared/dacctl_pkg.sv ----
package dacctl_pkg;
    localparam logic [31:0] DACCTL_ADDR_CONTROL = 32'hFFFF0600;
    localparam logic [31:0] DACCTL_ADDR_OUTPUT_VALUE = 32'hFFFF0604;
    localparam logic [15:0] DACCTL_CONTROL_RESET = 16'h0200;
    localparam logic [31:0] DACCTL_OUTPUT_VALUE_RESET = 32'h00000000;
    localparam logic [31:0] DACCTL_OUTPUT_VALUE_MASK = 32'h0FFFF000;
    localparam logic [15:0] DACCTL_CONTROL_MASK = 16'h03FF;
    localparam int DACCTL_CODE_HI = 27;
    localparam int DACCTL_CODE_LO = 16;
    localparam int DACCTL_EXTRA_HI = 15;
    localparam int DACCTL_EXTRA_LO = 12;
    localparam int DACCTL_BIT_POWERDOWN = 9;
    localparam int DACCTL_BIT_BUF_LOWPOWER = 8;
    localparam int DACCTL_BIT_AMPLIFIER = 7;
    localparam int DACCTL_BIT_BYPASS = 6;
    localparam int DACCTL_BIT_EDGE_SELECT = 5;
    localparam int DACCTL_BIT_OUTPUT_CLEAR = 4;
    localparam int DACCTL_BIT_INTERP = 3;
    localparam int DACCTL_BIT_RATE = 2;
    localparam int DACCTL_RANGE_HI = 1;
    localparam int DACCTL_RANGE_LO = 0;
    localparam logic [4:0] DACCTL_DIV_FAST = 5'h0F;
    localparam logic [4:0] DACCTL_DIV_SLOW = 5'h1F;
    typedef enum logic [1:0] {
        DACCTL_RANGE_INTERNAL = 2'h0,
        DACCTL_RANGE_EXTERNAL = 2'h1,
        DACCTL_RANGE_AUXILIARY = 2'h2,
        DACCTL_RANGE_SUPPLY = 2'h3
    } dacctl_range_type;
    typedef enum {
        DACCTL_MODE_NORMAL,
        DACCTL_MODE_INTERP,
        DACCTL_MODE_AMPLIFIER
    } dacctl_mode_type;
endpackage : dacctl_pkg

// ---- design/dacctl_divider.sv ----
`timescale 1ns/1ps
// Interpolation clock tick generator: one pulse every terminal+1 core cycles.
module dacctl_divider
    import dacctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [4:0] terminal,
    output logic tick
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic next_tick;

    always_comb begin
        next_count = 5'h00;
        next_tick = 1'b0;
        if (enable) begin
            if (count >= terminal) begin
                next_tick = 1'b1;
            end else begin
                next_count = count + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 5'h00;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : dacctl_divider

// ---- design/dacctl_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Output value 32 bits, code 27:16.
// - Interpolation adds bits 15:12 as low bits.
// - Output value resets zero, drives converter.
// - Software picks one of four reference spans.
// - Three modes: normal, interpolated, amplifier.
// - Normal mode is 12-bit, buffer on unless bypass bit set.
// - Bypass bit disables buffer, direct output.
// - Interpolation gives 16 bits at chosen rate.
// - Range field encodes 11,10,01,00 spans.
// - Output clear zeros output and register.
// - Edge select picks core clock or timer.
// - Interp bit; rate bit picks /16 or /32.
module dacctl_top
    import dacctl_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic TIMER_TICK,
    output logic [15:0] CONV_CODE,
    output logic CONV_LOAD,
    output logic CONV_POWERDOWN,
    output logic BUFFER_ENABLE,
    output logic BUFFER_LOWPOWER,
    output logic BUFFER_BYPASS,
    output logic BUFFER_AS_AMPLIFIER,
    output logic INTERP_ENABLE,
    output logic [1:0] RANGE_SELECT
);
    logic [15:0] converter_control;
    logic [31:0] dac_output_value;
    logic [15:0] next_converter_control;
    logic [31:0] next_dac_output_value;
    logic [31:0] next_rdata;
    logic [15:0] next_conv_code;
    logic next_conv_load;
    logic timer_meta;
    logic timer_sync;
    logic timer_prev;
    logic timer_fall;
    logic interp_tick;
    logic output_clear;
    logic [4:0] div_terminal;
    dacctl_mode_type mode;

    function automatic logic [15:0] build_code(input logic [31:0] value, input logic interp);
        logic [15:0] code;
        code = 16'h0000;
        code[15:4] = value[DACCTL_CODE_HI:DACCTL_CODE_LO];
        if (interp) begin
            code[3:0] = value[DACCTL_EXTRA_HI:DACCTL_EXTRA_LO];
        end
        return code;
    endfunction : build_code

    assign output_clear = ~converter_control[DACCTL_BIT_OUTPUT_CLEAR];

    always_comb begin
        if (converter_control[DACCTL_BIT_AMPLIFIER]) begin
            mode = DACCTL_MODE_AMPLIFIER;
        end else if (converter_control[DACCTL_BIT_INTERP]) begin
            mode = DACCTL_MODE_INTERP;
        end else begin
            mode = DACCTL_MODE_NORMAL;
        end
    end

    assign div_terminal = converter_control[DACCTL_BIT_RATE] ? DACCTL_DIV_FAST : DACCTL_DIV_SLOW;

    dacctl_divider u_divider (
        .clk(CLK),
        .rst_n(RST_N),
        .enable(mode == DACCTL_MODE_INTERP),
        .terminal(div_terminal),
        .tick(interp_tick)
    );

    // The timer comes from another block, so it is synchronised before edge detection.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            timer_meta <= 1'b0;
            timer_sync <= 1'b0;
            timer_prev <= 1'b0;
        end else begin
            timer_meta <= TIMER_TICK;
            timer_sync <= timer_meta;
            timer_prev <= timer_sync;
        end
    end
    assign timer_fall = timer_prev & ~timer_sync;

    always_comb begin
        next_converter_control = converter_control;
        next_dac_output_value = dac_output_value;
        next_rdata = 32'h00000000;
        if (WR && ADDR == DACCTL_ADDR_CONTROL) begin
            next_converter_control = WDATA[15:0] & DACCTL_CONTROL_MASK;
        end
        if (WR && ADDR == DACCTL_ADDR_OUTPUT_VALUE) begin
            next_dac_output_value = WDATA & DACCTL_OUTPUT_VALUE_MASK;
        end
        if (!next_converter_control[DACCTL_BIT_OUTPUT_CLEAR]) begin
            next_dac_output_value = DACCTL_OUTPUT_VALUE_RESET;
        end
        if (RD) begin
            case (ADDR)
                DACCTL_ADDR_CONTROL: next_rdata = {16'h0000, converter_control};
                DACCTL_ADDR_OUTPUT_VALUE: next_rdata = dac_output_value;
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    // Loading is done on a core clock edge; a timer falling edge is detected after synchronisation and loads on the next edge.
    always_comb begin
        next_conv_load = 1'b0;
        case (mode)
            DACCTL_MODE_INTERP: next_conv_load = interp_tick;
            DACCTL_MODE_NORMAL: next_conv_load = converter_control[DACCTL_BIT_EDGE_SELECT]
                ? timer_fall : 1'b1;
            default: next_conv_load = 1'b0;
        endcase
        next_conv_code = CONV_CODE;
        if (output_clear) begin
            next_conv_code = 16'h0000;
        end else if (next_conv_load) begin
            next_conv_code = build_code(dac_output_value, mode == DACCTL_MODE_INTERP);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            converter_control <= DACCTL_CONTROL_RESET;
            dac_output_value <= DACCTL_OUTPUT_VALUE_RESET;
            RDATA <= 32'h00000000;
            CONV_CODE <= 16'h0000;
            CONV_LOAD <= 1'b0;
        end else begin
            converter_control <= next_converter_control;
            dac_output_value <= next_dac_output_value;
            RDATA <= next_rdata;
            CONV_CODE <= next_conv_code;
            CONV_LOAD <= next_conv_load;
        end
    end

    assign RANGE_SELECT = converter_control[DACCTL_RANGE_HI:DACCTL_RANGE_LO];
    assign CONV_POWERDOWN = converter_control[DACCTL_BIT_POWERDOWN];
    assign BUFFER_ENABLE = ~converter_control[DACCTL_BIT_BYPASS];
    assign BUFFER_BYPASS = converter_control[DACCTL_BIT_BYPASS];
    assign BUFFER_LOWPOWER = converter_control[DACCTL_BIT_BUF_LOWPOWER];
    assign BUFFER_AS_AMPLIFIER = (mode == DACCTL_MODE_AMPLIFIER);
    assign INTERP_ENABLE = (mode == DACCTL_MODE_INTERP);

    property p_reserved_zero;
        @(posedge CLK) disable iff (!RST_N) (dac_output_value & ~DACCTL_OUTPUT_VALUE_MASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set.");

    property p_clear_zero;
        @(posedge CLK) disable iff (!RST_N) output_clear |=> (CONV_CODE == 16'h0000);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("Clear did not zero.");

    property p_normal_load;
        @(posedge CLK) disable iff (!RST_N)
            (mode == DACCTL_MODE_NORMAL && !converter_control[DACCTL_BIT_EDGE_SELECT]
             && !output_clear) |=> (CONV_CODE == {$past(dac_output_value[27:16]), 4'h0});
    endproperty
    a_normal_load: assert property (p_normal_load) else $error("Normal code wrong.");

    property p_interp_tick;
        @(posedge CLK) disable iff (!RST_N)
            (INTERP_ENABLE && interp_tick) |-> ##1 !interp_tick [*8];
    endproperty
    a_interp_tick: assert property (p_interp_tick) else $error("Tick too fast.");

    property p_bypass;
        @(posedge CLK) disable iff (!RST_N) BUFFER_BYPASS |-> !BUFFER_ENABLE;
    endproperty
    a_bypass: assert property (p_bypass) else $error("Buffer on in bypass.");

    property p_clear_register;
        @(posedge CLK) disable iff (!RST_N) output_clear |=> (dac_output_value == 32'h0);
    endproperty
    a_clear_register: assert property (p_clear_register) else $error("Clear left value.");

    sequence s_timer_paced;
        (mode == DACCTL_MODE_NORMAL) && converter_control[DACCTL_BIT_EDGE_SELECT] && timer_fall;
    endsequence
    property p_timer_load;
        @(posedge CLK) disable iff (!RST_N) s_timer_paced |=> CONV_LOAD;
    endproperty
    a_timer_load: assert property (p_timer_load) else $error("Timer edge not loaded.");
endmodule : dacctl_top

// ---- verification/dacctl_load_model.sv ----
`timescale 1ns/1ps
module dacctl_load_model (
    input wire logic clk,
    input wire logic [15:0] code,
    input wire logic load,
    output logic [15:0] level
);
    // The load follows the converter only when a new code is strobed in.
    always_ff @(posedge clk) begin
        if (load) begin
            level <= code;
        end
    end
endmodule : dacctl_load_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
    import dacctl_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b1;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, got;
    logic [15:0] code, level;
    logic load, pd, lp, en, byp, amp, intp;
    logic [1:0] rng;
    int mismatches = 0, samples_checked = 0;
    // Row: control, value, readback, code, status {pd,lp,en,byp,amp,int,range}.
    logic [31:0] rows [6][5] = '{
        '{32'h0013, 32'h0ABC5000, 32'h0ABC5000, 32'hABC0, 32'h23},
        '{32'h0052, 32'h0FFF0000, 32'h0FFF0000, 32'hFFF0, 32'h12},
        '{32'h0011, 32'h00010000, 32'h00010000, 32'h0010, 32'h21},
        '{32'h001C, 32'h0123F000, 32'h0123F000, 32'h123F, 32'h24},
        '{32'h0018, 32'h0FFFF000, 32'h0FFFF000, 32'hFFFF, 32'h24},
        '{32'h0398, 32'h00000000, 32'h00000000, 32'h0000, 32'hE8}};
    always #50 clk = ~clk;
    dacctl_top DUT (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .TIMER_TICK(tick), .CONV_CODE(code), .CONV_LOAD(load),
        .CONV_POWERDOWN(pd), .BUFFER_ENABLE(en), .BUFFER_LOWPOWER(lp), .BUFFER_BYPASS(byp),
        .BUFFER_AS_AMPLIFIER(amp), .INTERP_ENABLE(intp), .RANGE_SELECT(rng));
    dacctl_load_model load_model (.clk(clk), .code(code), .load(load), .level(level));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [31:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask : bus_rd
    task automatic rate_check(input logic [31:0] ctl, input int period);
        int n;
        int gap;
        bus_wr(DACCTL_ADDR_CONTROL, ctl);
        n = 0;
        @(posedge clk);
        #1;
        while (!load && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        chk(n < 100, 1'b1);
        gap = 1;
        @(posedge clk);
        #1;
        while (!load && gap < 100) begin
            @(posedge clk);
            #1 gap++;
        end
        chk(gap, period);
    endtask : rate_check
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        bus_rd(DACCTL_ADDR_CONTROL);
        chk(got, 32'h0200);
        bus_rd(DACCTL_ADDR_OUTPUT_VALUE);
        chk(got, 32'h0);
        chk({pd, lp, en, byp, amp, intp, rng}, 32'hA0);
        // The last row keeps the converter powered down while the buffer amplifies.
        // amplifier row powered down
        for (int i = 0; i < 6; i++) begin
            bus_wr(DACCTL_ADDR_CONTROL, rows[i][0]);
            bus_wr(DACCTL_ADDR_OUTPUT_VALUE, rows[i][1]);
            repeat (70) @(posedge clk);
            #1 chk({pd, lp, en, byp, amp, intp, rng}, rows[i][4]);
            if (i < 5) chk(level, rows[i][3]);
            else chk(load, 32'h0);
            bus_rd(DACCTL_ADDR_OUTPUT_VALUE);
            chk(got, rows[i][2]);
        end
        bus_wr(DACCTL_ADDR_CONTROL, 32'h0013);
        bus_wr(DACCTL_ADDR_OUTPUT_VALUE, 32'h01110000);
        repeat (5) @(posedge clk);
        // Timer-paced updates must wait for the tick to fall.
        bus_wr(DACCTL_ADDR_CONTROL, 32'h0033);
        bus_wr(DACCTL_ADDR_OUTPUT_VALUE, 32'h02220000);
        repeat (10) @(posedge clk);
        #1 chk(level, 32'h1110);
        chk(load, 32'h0);
        @(posedge clk) tick <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk(level, 32'h2220);
        @(posedge clk) tick <= 1'b1;
        bus_wr(DACCTL_ADDR_CONTROL, 32'h0023);
        repeat (3) @(posedge clk);
        #1 chk(code, 32'h0);
        bus_rd(DACCTL_ADDR_OUTPUT_VALUE);
        chk(got, 32'h0);
        bus_wr(DACCTL_ADDR_CONTROL, 32'h0013);
        bus_wr(DACCTL_ADDR_OUTPUT_VALUE, 32'hFFFFFFFF);
        bus_rd(DACCTL_ADDR_OUTPUT_VALUE);
        chk(got, 32'h0FFFF000);
        bus_rd(32'hFFFF0608);
        chk(got, 32'h0);
        rate_check(32'h001C, 16);
        rate_check(32'h0018, 32);
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus_rd(DACCTL_ADDR_CONTROL);
        chk(got, 32'h0200);
        chk({pd, lp, en, byp, amp, intp, rng}, 32'hA0);
        bus_rd(DACCTL_ADDR_OUTPUT_VALUE);
        chk(got, 32'h0);
        tally_and_finish();
    end
endmodule : tb
